//--- verilog/psq_core.sv
// Purpose: program sequencer of a small ROM-less 4-bit controller
// Assumes: external PROM plus address latch on the multiplexed bus
// Notes: executes only sequencing, skip, enable-register, accumulator and RAM-pointer ops
`timescale 1ns/10ps
module psq_core
	import psq_pkg::*;
#(
	parameter int PC_W = PSQ_PC_W,
	parameter int STACK_DEPTH = PSQ_STACK_DEPTH
)
(
	// Clock and active-high synchronous reset
	input wire logic clk_sys,
	input wire logic rst,
	// Program memory bus
	input wire logic [7:0] multiplexed_rom_bus_in,
	output logic [7:0] multiplexed_rom_bus_out,
	output logic multiplexed_rom_bus_oe,
	output logic [1:0] upper_rom_address,
	output logic addr_data_phase,
	// Interrupt pin
	input wire logic interrupt_input,
	// Status and cleared outputs
	output logic sync_clock_output,
	output logic [3:0] accumulator,
	output logic [5:0] ram_pointer,
	output logic carry_flag,
	output logic [3:0] digit_port,
	output logic [3:0] feature_enable,
	output logic [3:0] general_port,
	output logic serial_output,
	output logic irq_ack
);
	// ==========================================================
	// Declarations
	logic [3:0] phase_cnt;
	logic [3:0] next_phase_cnt;
	logic cycle_tick;
	logic [PC_W-1:0] pc;
	logic [PC_W-1:0] next_pc;
	logic [PC_W-1:0] stack [STACK_DEPTH];
	logic [PC_W-1:0] next_stack [STACK_DEPTH];
	logic skip_save [STACK_DEPTH];
	logic next_skip_save [STACK_DEPTH];
	logic skip_pend;
	logic next_skip_pend;
	logic irq_pend;
	logic next_irq_pend;
	logic chain_hold;
	logic next_chain_hold;
	logic [7:0] first_byte;
	logic [7:0] next_first_byte;
	psq_state_t state;
	psq_state_t next_state;
	logic [3:0] next_acc;
	logic [5:0] next_ptr;
	logic next_carry;
	logic [3:0] next_en;
	logic next_sync;
	logic next_ack;
	logic irq_seen;
	logic [7:0] op;
	logic is_lbi;
	logic [4:0] sum;

	// ==========================================================
	// Interrupt pulse qualifier
	psq_irq_detect u_detect (
		.clk_sys(clk_sys),
		.rst(rst),
		.cycle_tick(cycle_tick),
		.interrupt_input(interrupt_input),
		.irq_seen(irq_seen)
	);

	// ==========================================================
	// Cycle divider: instruction executes on the last clock of the cycle
	always_comb begin
		next_phase_cnt = phase_cnt + 4'h1;
	end
	assign cycle_tick = (phase_cnt == 4'(PSQ_CLK_PER_CYCLE - 1));

	// ==========================================================
	// Bus pins: address half, then release for the PROM byte
	assign upper_rom_address = pc[PC_W-1 -: 2];
	assign multiplexed_rom_bus_oe = addr_data_phase;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			phase_cnt <= 4'h0;
			addr_data_phase <= 1'b1;
			multiplexed_rom_bus_out <= 8'h00;
		end else begin
			phase_cnt <= next_phase_cnt;
			addr_data_phase <= (next_phase_cnt < PSQ_PHASE_HALF);
			// Follow the next address so the bus and upper bits change together
			multiplexed_rom_bus_out <= next_pc[7:0];
		end
	end

	// ==========================================================
	// Decode helpers
	assign op = multiplexed_rom_bus_in; // sampled late in data phase
	assign is_lbi = (op[7:6] == 2'b00) && (op[3:0] >= 4'h8 || op[3:0] == 4'hF);
	assign sum = {1'b0, accumulator} + {4'h0, carry_flag};

	// ==========================================================
	// Sequencer: fetch, skip, transfer, interrupt
	always_comb begin
		next_pc = pc;
		next_stack = stack;
		next_skip_save = skip_save;
		next_skip_pend = skip_pend;
		next_irq_pend = irq_pend | (irq_seen & feature_enable[PSQ_EN_IRQ_BIT]);
		next_chain_hold = chain_hold;
		next_first_byte = first_byte;
		next_state = state;
		next_acc = accumulator;
		next_ptr = ram_pointer;
		next_carry = carry_flag;
		next_en = feature_enable;
		next_ack = 1'b0;
		if (cycle_tick) begin
			next_pc = pc + PC_W'(1);
			case (state)
			PSQ_ST_FETCH: begin
				next_chain_hold = 1'b0;
				if (skip_pend) begin
					next_skip_pend = 1'b0;
					if (op == PSQ_OP_PREFIX || op[7:4] == PSQ_OP_JUMP_HI) begin
						next_state = PSQ_ST_SECOND;
						next_skip_pend = 1'b1; // skip both bytes
					end
				end else if (op == PSQ_OP_PREFIX || op[7:4] == PSQ_OP_JUMP_HI) begin
					next_first_byte = op;
					next_state = PSQ_ST_SECOND;
				end else if (op == PSQ_OP_JUMP_IND) begin
					next_state = PSQ_ST_JIND;
				end else if (op == PSQ_OP_CLEAR_ACC) begin
					next_acc = 4'h0;
				end else if (op == PSQ_OP_ADD_CARRY_SKIP) begin
					next_acc = sum[3:0];
					next_carry = sum[4];
					next_skip_pend = sum[4];
				end else if (op == PSQ_OP_RET || op == PSQ_OP_RETSK) begin
					next_pc = stack[0];
					next_skip_pend = skip_save[0] | (op == PSQ_OP_RETSK);
					for (int i = 0; i < STACK_DEPTH - 1; i++) begin
						next_stack[i] = stack[i+1];
						next_skip_save[i] = skip_save[i+1];
					end
					next_chain_hold = 1'b1;
				end else if (op[7:6] == 2'b10) begin
					next_stack[0] = pc + PC_W'(1);
					next_skip_save[0] = 1'b0;
					for (int i = 1; i < STACK_DEPTH; i++) begin
						next_stack[i] = stack[i-1];
						next_skip_save[i] = skip_save[i-1];
					end
					next_pc = {4'h2, op[5:0]};
					next_chain_hold = 1'b1;
				end else if (op[7]) begin
					next_pc = (pc[9:7] == 3'h1) ? {pc[9:7], op[6:0]} : {pc[9:6], op[5:0]};
					next_chain_hold = 1'b1;
				end else if (is_lbi) begin
					next_ptr = {op[5:4], op[3:0] + 4'h1};
					next_chain_hold = 1'b1;
				end
			end
			PSQ_ST_SECOND: begin
				next_state = PSQ_ST_FETCH;
				if (skip_pend) begin
					next_skip_pend = 1'b0;
				end else if (first_byte[7:4] == PSQ_OP_JUMP_HI) begin
					if (first_byte[3]) begin
						next_stack[0] = pc + PC_W'(1);
						next_skip_save[0] = 1'b0;
						for (int i = 1; i < STACK_DEPTH; i++) begin
							next_stack[i] = stack[i-1];
							next_skip_save[i] = skip_save[i-1];
						end
					end
					next_pc = {first_byte[1:0], op};
					next_chain_hold = 1'b1;
				end else if (op[7:4] == PSQ_OP_LEI_HI) begin
					next_en = op[3:0]; // enable register load
				end else if (op[7:6] == 2'b10) begin
					next_ptr = op[5:0];
					next_chain_hold = 1'b1;
				end
			end
			PSQ_ST_JIND: begin
				next_state = PSQ_ST_FETCH;
				next_pc = {pc[9:8], op};
				next_chain_hold = 1'b1;
			end
			default: next_state = PSQ_ST_FETCH;
			endcase
			// Take the interrupt only between whole instructions
			if (irq_pend && feature_enable[PSQ_EN_IRQ_BIT] && next_state == PSQ_ST_FETCH &&
				!next_chain_hold) begin
				next_stack[0] = next_pc;
				next_skip_save[0] = next_skip_pend;
				for (int i = STACK_DEPTH - 1; i > 0; i--) begin
					next_stack[i] = (i == 1) ? stack[0] : stack[i-1];
					next_skip_save[i] = skip_save[i-1];
				end
				next_skip_pend = 1'b0;
				next_pc = PSQ_IRQ_VECTOR;
				next_en[PSQ_EN_IRQ_BIT] = 1'b0;
				next_irq_pend = 1'b0;
				next_ack = 1'b1;
			end
		end
		next_sync = (phase_cnt < PSQ_PHASE_HALF);
	end

	// Sequencer registers; reset clears program and working state
	// Data RAM sits outside this block and keeps its contents
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pc <= PSQ_RESET_PC;
			for (int i = 0; i < STACK_DEPTH; i++) begin
				stack[i] <= '0;
				skip_save[i] <= 1'b0;
			end
			skip_pend <= 1'b0;
			irq_pend <= 1'b0;
			chain_hold <= 1'b0;
			first_byte <= 8'h00;
			state <= PSQ_ST_FETCH;
			accumulator <= 4'h0;
			ram_pointer <= 6'h00;
			carry_flag <= 1'b0;
			digit_port <= 4'h0;
			feature_enable <= PSQ_EN_RESET;
			general_port <= 4'h0;
			serial_output <= 1'b0;
			sync_clock_output <= 1'b0;
			irq_ack <= 1'b0;
		end else begin
			pc <= next_pc;
			stack <= next_stack;
			skip_save <= next_skip_save;
			skip_pend <= next_skip_pend;
			irq_pend <= next_irq_pend;
			chain_hold <= next_chain_hold;
			first_byte <= next_first_byte;
			state <= next_state;
			accumulator <= next_acc;
			ram_pointer <= next_ptr;
			carry_flag <= next_carry;
			digit_port <= digit_port;
			feature_enable <= next_en;
			general_port <= general_port;
			serial_output <= serial_output;
			sync_clock_output <= next_sync;
			irq_ack <= next_ack;
		end
	end
endmodule

//--- include/psq_pkg.sv
// Purpose: shared constants for the program sequencer core
// Assumes: 4-bit controller, 10-bit program address, 8-bit instruction bus
// Notes: cycle timing is in input clock periods
package psq_pkg;
	// ==========================================================
	// Geometry
	localparam int PSQ_PC_W = 10;
	localparam int PSQ_BUS_W = 8;
	localparam int PSQ_STACK_DEPTH = 3;
	// ==========================================================
	// Timing
	localparam int PSQ_CLK_PER_CYCLE = 16;
	localparam int PSQ_PHASE_CNT_W = 4;
	localparam logic [3:0] PSQ_PHASE_HALF = 4'h8;
	localparam int PSQ_RESET_MIN_CYCLES = 2;
	localparam int PSQ_IRQ_MIN_CYCLES = 2;
	// ==========================================================
	// Addresses and reset values
	localparam logic [9:0] PSQ_RESET_PC = 10'h000;
	localparam logic [9:0] PSQ_IRQ_VECTOR = 10'h0FF;
	localparam logic [3:0] PSQ_EN_RESET = 4'h0;
	localparam int PSQ_EN_IRQ_BIT = 1;
	// ==========================================================
	// Opcodes the sequencer decodes
	localparam logic [7:0] PSQ_OP_CLEAR_ACC = 8'h00;
	localparam logic [7:0] PSQ_OP_NOP = 8'h44;
	localparam logic [7:0] PSQ_OP_RET = 8'h48;
	localparam logic [7:0] PSQ_OP_RETSK = 8'h49;
	localparam logic [7:0] PSQ_OP_ADD_CARRY_SKIP = 8'h30;
	localparam logic [7:0] PSQ_OP_PREFIX = 8'h33;
	localparam logic [3:0] PSQ_OP_JUMP_HI = 4'h6;
	localparam logic [3:0] PSQ_OP_LEI_HI = 4'h6;
	localparam logic [7:0] PSQ_OP_JUMP_IND = 8'hFF;
	// Sequencer states
	typedef enum logic [1:0] {PSQ_ST_FETCH, PSQ_ST_SECOND, PSQ_ST_JIND} psq_state_t;
endpackage

//--- verilog/psq_irq_detect.sv
// Purpose: synchronise the interrupt pin and qualify a falling pulse
// Assumes: pulse held low at least two instruction cycles
// Notes: qualification counted on cycle strobes
`timescale 1ns/10ps
module psq_irq_detect
	import psq_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Cycle strobe and pin
	input wire logic cycle_tick,
	input wire logic interrupt_input,
	// Qualified pulse
	output logic irq_seen
);
	logic sync_a;
	logic sync_b;
	logic armed;
	logic [1:0] low_cnt;
	logic next_armed;
	logic [1:0] next_low_cnt;
	logic next_irq_seen;

	// ==========================================================
	// Two-stage synchroniser; only sync_b feeds logic
	always_ff @(posedge clk_sys) begin
		sync_a <= interrupt_input;
		sync_b <= sync_a;
	end

	// Arm on high, count low cycles after the fall
	always_comb begin
		next_armed = armed;
		next_low_cnt = low_cnt;
		next_irq_seen = 1'b0;
		if (sync_b) begin
			next_armed = 1'b1;
			next_low_cnt = 2'h0;
		end else if (armed && cycle_tick) begin
			next_low_cnt = low_cnt + 2'h1;
			if (low_cnt == 2'(PSQ_IRQ_MIN_CYCLES - 1)) begin
				next_irq_seen = 1'b1;
				next_armed = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			armed <= 1'b0;
			low_cnt <= 2'h0;
			irq_seen <= 1'b0;
		end else begin
			armed <= next_armed;
			low_cnt <= next_low_cnt;
			irq_seen <= next_irq_seen;
		end
	end
endmodule

//--- dv/psq_rom_model.sv
// Purpose: program memory with address latch for the sequencer core
// Assumes: latch closes on the phase fall, memory answers in data phase
// Notes: undriven bus shows the inverse of the last address
`timescale 1ns/10ps
module psq_rom_model (
	// Device side of the bus
	input wire logic [7:0] bus_out,
	input wire logic bus_oe,
	input wire logic [1:0] upper_addr,
	input wire logic phase,
	// Wire level seen by the device
	output logic [7:0] bus_in
);
	logic [7:0] mem [0:1023];
	logic [9:0] addr = 10'h000;
	int fetch_cnt = 0;
	// ==========================================
	// Default image: no-ops, clear at reset entry
	initial begin
		for (int i = 0; i < 1024; i++) begin
			mem[i] = 8'h44;
		end
		mem[0] = 8'h00;
		mem[255] = 8'h44;
	end
	// Low address captured on the falling phase edge
	always @(negedge phase) begin
		addr = {upper_addr, bus_out};
		fetch_cnt++;
	end
	// Memory drives only in data phase; otherwise a changing value
	assign bus_in = bus_oe ? bus_out : (phase ? ~bus_out : mem[addr]);
endmodule

//--- dv/psq_core_properties.sv
// Purpose: port checker for the program sequencer core
// Assumes: one clock, synchronous active-high reset
// Notes: bound onto every core instance
`timescale 1ns/10ps
module psq_core_checker
	import psq_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Memory bus
	input wire logic [7:0] multiplexed_rom_bus_out,
	input wire logic multiplexed_rom_bus_oe,
	input wire logic [1:0] upper_rom_address,
	input wire logic addr_data_phase,
	// Status
	input wire logic sync_clock_output,
	input wire logic [3:0] accumulator,
	input wire logic [5:0] ram_pointer,
	input wire logic carry_flag,
	input wire logic [3:0] digit_port,
	input wire logic [3:0] feature_enable,
	input wire logic [3:0] general_port,
	input wire logic serial_output,
	input wire logic irq_ack
);
	// ==========================================
	// Framing and interrupt relations
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_oe_phase;
		multiplexed_rom_bus_oe == addr_data_phase;
	endproperty
	a_oe_phase: assert property (p_oe_phase) else $error("bus enable off phase");
	property p_addr_half;
		$rose(addr_data_phase) |-> addr_data_phase [*8] ##1 !addr_data_phase;
	endproperty
	a_addr_half: assert property (p_addr_half) else $error("address phase length");
	property p_data_half;
		$fell(addr_data_phase) |-> !addr_data_phase [*8] ##1 addr_data_phase;
	endproperty
	a_data_half: assert property (p_data_half) else $error("data phase length");
	property p_addr_hold;
		addr_data_phase && !$rose(addr_data_phase) |->
			$stable(multiplexed_rom_bus_out) && $stable(upper_rom_address);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address moved");
	// Reset must not disable its own check
	property p_reset_clear;
		disable iff (1'b0) rst |=> addr_data_phase && {upper_rom_address,
			multiplexed_rom_bus_out, accumulator, ram_pointer, carry_flag, digit_port,
			feature_enable, general_port, serial_output, irq_ack} == 35'h0;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset not clear");
	property p_ack_vector;
		irq_ack |-> ##[1:17] (addr_data_phase &&
			{upper_rom_address, multiplexed_rom_bus_out} == PSQ_IRQ_VECTOR);
	endproperty
	a_ack_vector: assert property (p_ack_vector) else $error("no vector fetch");
	property p_ack_en;
		irq_ack |-> $past(feature_enable[1]) ##1 !feature_enable[1];
	endproperty
	a_ack_en: assert property (p_ack_en) else $error("enable bit wrong at ack");
	property p_ack_once;
		irq_ack |=> !irq_ack [*8];
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack repeated");
	property p_sync_rate;
		$rose(sync_clock_output) |-> ##16 $rose(sync_clock_output);
	endproperty
	a_sync_rate: assert property (p_sync_rate) else $error("sync period");
endmodule
bind psq_core psq_core_checker u_chk (
	.clk_sys(clk_sys), .rst(rst), .multiplexed_rom_bus_out(multiplexed_rom_bus_out),
	.multiplexed_rom_bus_oe(multiplexed_rom_bus_oe), .upper_rom_address(upper_rom_address),
	.addr_data_phase(addr_data_phase), .sync_clock_output(sync_clock_output),
	.accumulator(accumulator), .ram_pointer(ram_pointer), .carry_flag(carry_flag),
	.digit_port(digit_port), .feature_enable(feature_enable), .general_port(general_port),
	.serial_output(serial_output), .irq_ack(irq_ack)
);

//--- dv/test_program_sequencer_core.sv
// Purpose: directed bench for the program sequencer core
// Assumes: memory model on the bus, inputs driven on the falling edge
// Notes: fetch addresses are read back from the model's latch
`timescale 1ns/10ps
module test_program_sequencer_core
	import psq_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic interrupt_input = 1'b1;
	logic [7:0] bus_in, bus_out;
	logic [1:0] upper;
	logic [3:0] acc, dig, en, gio;
	logic [5:0] ptr;
	logic oe, phase, sync, cy, so, ack;
	logic [9:0] a, prev, ret;
	int fails = 0;
	int total_checks = 0;
	int ack_cnt = 0;
	// ==========================================
	// Clock, device and memory
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (ack === 1'b1) ack_cnt++;
	psq_core u_dut (.clk_sys(clk_sys), .rst(rst), .multiplexed_rom_bus_in(bus_in),
		.multiplexed_rom_bus_out(bus_out), .multiplexed_rom_bus_oe(oe),
		.upper_rom_address(upper), .addr_data_phase(phase), .interrupt_input(interrupt_input),
		.sync_clock_output(sync), .accumulator(acc), .ram_pointer(ptr), .carry_flag(cy),
		.digit_port(dig), .feature_enable(en), .general_port(gio), .serial_output(so),
		.irq_ack(ack));
	psq_rom_model u_rom (.bus_out(bus_out), .bus_oe(oe), .upper_addr(upper), .phase(phase),
		.bus_in(bus_in));
	// ==========================================
	// Shared helpers
	task automatic check(input logic [34:0] got, input logic [34:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("Checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Bounded wait for the next latched fetch address
	task automatic next_fetch(output logic [9:0] adr);
		int start;
		start = u_rom.fetch_cnt;
		for (int i = 0; i < 40 && u_rom.fetch_cnt == start; i++) begin
			@(negedge clk_sys);
		end
		adr = u_rom.addr;
		if (u_rom.fetch_cnt == start) begin
			fails++;
			$display("ERROR %0t no fetch seen", $time);
			end_sim();
		end
	endtask
	// ==========================================
	// Scenarios
	task automatic do_reset(input int clocks);
		rst = 1'b1;
		repeat (clocks) @(negedge clk_sys);
		check({phase, acc, ptr, cy, dig, en, gio, so, upper, bus_out}, {1'b1, 34'h0});
		rst = 1'b0;
		next_fetch(a);
		check(35'(a), 35'(0));
		$display("reset test done");
	endtask
	task automatic test_flow();
		next_fetch(a);
		check(35'(a), 35'(1));
		next_fetch(a);
		next_fetch(a);
		check(35'(a), 35'(3));
		next_fetch(a);
		check(35'(a), 35'(10'h123));
		next_fetch(a);
		next_fetch(a);
		check(35'(a), 35'(10'h125));
		check(35'(en), 35'(4'h2));
		$display("flow test done");
	endtask
	task automatic test_irq();
		interrupt_input = 1'b0;
		for (int i = 0; i < 12 && a != PSQ_IRQ_VECTOR; i++) begin
			prev = a;
			next_fetch(a);
			if (i == 3) interrupt_input = 1'b1;
		end
		interrupt_input = 1'b1;
		check(35'(a), 35'(PSQ_IRQ_VECTOR));
		check(35'(ack_cnt), 35'(1));
		check(35'(en), 35'(4'h0));
		ret = prev + 10'h1;
		next_fetch(a);
		next_fetch(a);
		check(35'(a), 35'(ret));
		$display("interrupt test done");
	endtask
	task automatic test_masked();
		interrupt_input = 1'b0;
		repeat (4) next_fetch(a);
		interrupt_input = 1'b1;
		repeat (4) next_fetch(a);
		check(35'(a), 35'(ret + 10'h8));
		check(35'(ack_cnt), 35'(1));
		$display("masked test done");
	endtask
	// ==========================================
	// Main sequence: jump to page 1, enable, interrupt, return
	initial begin
		@(negedge clk_sys);
		u_rom.mem[2] = 8'h61;
		u_rom.mem[3] = 8'h23;
		u_rom.mem[10'h123] = 8'h33;
		u_rom.mem[10'h124] = 8'h62;
		u_rom.mem[10'h100] = 8'h48;
		do_reset(15);
		test_flow();
		test_irq();
		test_masked();
		do_reset(32);
		end_sim();
	end
endmodule
